// >>> hw/mosu_pkg.sv
// Package for the memory ordering and synchronization unit.
// Assumes a single core clock; all counts are in core cycles.
package mosu_pkg;

  localparam int unsigned MOSU_ADDR_W   = 32;
  localparam int unsigned MOSU_DATA_W   = 32;
  localparam int unsigned MOSU_SQ_DEPTH = 4;
  localparam int unsigned MOSU_SQ_IDX_W = 2;
  localparam int unsigned MOSU_BE_W     = 4;

  // Word alignment mask for store gathering (same aligned word may merge)
  localparam logic [1:0] MOSU_WORD_OFS_ZERO = 2'h0;

  // Operation kinds arriving from dispatch
  typedef enum logic [2:0] {
    MOSU_OP_LOAD,
    MOSU_OP_STORE,
    MOSU_OP_ORDER_BARRIER,
    MOSU_OP_FULL_BARRIER,
    MOSU_OP_INSN_SYNC
  } mosu_op_t;

  // Bus transaction kinds sent to the bus interface unit
  typedef enum logic [1:0] {
    MOSU_BUS_READ,
    MOSU_BUS_WRITE,
    MOSU_BUS_ORDER_BCAST,
    MOSU_BUS_FULL_BCAST
  } mosu_bus_kind_t;

  // One request from dispatch
  typedef struct packed {
    mosu_op_t                 op;
    logic                     uncached;   // Cache-inhibited or write-through
    logic [MOSU_ADDR_W-1:0]   addr;
    logic [MOSU_DATA_W-1:0]   data;
    logic [MOSU_BE_W-1:0]     be;
  } mosu_req_t;

  // One store queue entry
  typedef struct packed {
    logic                     valid;
    logic                     barrier;    // Ordering barrier marker
    logic                     uncached;
    logic [MOSU_ADDR_W-1:0]   addr;
    logic [MOSU_DATA_W-1:0]   data;
    logic [MOSU_BE_W-1:0]     be;
  } mosu_sq_entry_t;

  // One request to the bus interface unit
  typedef struct packed {
    mosu_bus_kind_t           kind;
    logic [MOSU_ADDR_W-1:0]   addr;
    logic [MOSU_DATA_W-1:0]   data;
    logic [MOSU_BE_W-1:0]     be;
  } mosu_bus_req_t;

endpackage

// >>> hw/mosu_core.sv
// Memory ordering and synchronization unit: store queue with gathering,
// I/O ordering barrier, full barrier and instruction-synchronize control.
// Assumes dispatch, bus interface unit and completion logic share the core clock.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1 - Ordering barrier goes to load/store path, runs after older uncached accesses.
// RULE2 - Younger uncached accesses wait until the ordering barrier has executed.
// RULE3 - With broadcast enable set, ordering barrier is sent on the external bus.
// RULE4 - Barrier transaction bypasses the L2 and goes straight to the bus unit.
// RULE5 - With broadcast enable clear, ordering barrier completes internally, no bus transaction.
// RULE6 - Uncached accesses are never reordered among themselves.
// RULE7 - Store gathering never merges stores across a queued ordering barrier.
// RULE8 - External agents must not gather stores across a broadcast barrier.
// RULE9 - Instruction sync flushes instruction queue, waits for older instructions, refetches.
// RULE10 - Refetched instruction waits until older ones can no longer raise exceptions.
// RULE11 - Instruction sync does not wait for store queue draining.
// RULE12 - Instructions after instruction sync see all prior architectural effects.
// RULE13 - Ordering barrier completion time may vary with system state.
// RULE14 - With broadcast enable set, full barrier completes only after its broadcast.
module mosu_core
  import mosu_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           rstn,
  input  wire logic           address_broadcast_enable,
  input  wire logic           gather_enable,
  input  wire logic           req_valid,
  input  wire mosu_req_t      req,
  output logic                req_ready,
  input  wire logic           older_done,
  input  wire logic           older_no_except,
  output logic                iq_flush,
  output logic                refetch,
  output logic                exec_hold,
  output logic                bus_valid,
  output mosu_bus_req_t       bus_req,
  input  wire logic           bus_ack,
  output logic                barrier_done,
  output logic                l2_bypass
);

  typedef enum {
    MOSU_S_IDLE,
    MOSU_S_ISYNC_WAIT,
    MOSU_S_ISYNC_HOLD,
    MOSU_S_FULL_DRAIN,
    MOSU_S_FULL_BCAST
  } mosu_state_t;

  mosu_state_t                        state_reg;
  mosu_sq_entry_t [MOSU_SQ_DEPTH-1:0] sq_reg;
  logic [MOSU_SQ_IDX_W:0]             count_reg;
  logic                               bus_valid_reg;
  mosu_bus_req_t                      bus_req_reg;
  logic                               iq_flush_reg;
  logic                               refetch_reg;
  logic                               exec_hold_reg;
  logic                               barrier_done_reg;
  logic                               l2_bypass_reg;

  logic                               sq_full;
  logic                               sq_empty;
  logic                               tail_valid;
  mosu_sq_entry_t                     tail_entry;
  logic                               is_store;
  logic                               is_order;
  logic                               can_gather;
  logic                               push;
  logic                               pop;
  logic                               launch;
  logic                               head_is_local_barrier;
  logic [MOSU_DATA_W-1:0]             merged_data;
  logic [MOSU_BE_W-1:0]               merged_be;

  assign sq_full    = (count_reg == (MOSU_SQ_IDX_W+1)'(MOSU_SQ_DEPTH));
  assign sq_empty   = (count_reg == '0);
  assign tail_valid = !sq_empty;
  assign tail_entry = tail_valid ? sq_reg[count_reg - 1'b1] : '0;
  assign is_store   = (req.op == MOSU_OP_STORE);
  assign is_order   = (req.op == MOSU_OP_ORDER_BARRIER);

  // Gather only cacheable stores into the same word, and never past a barrier entry
  assign can_gather = gather_enable && is_store && !req.uncached && tail_valid
                      && !tail_entry.barrier && !tail_entry.uncached
                      && (tail_entry.addr[MOSU_ADDR_W-1:2] == req.addr[MOSU_ADDR_W-1:2])
                      && (count_reg > (MOSU_SQ_IDX_W+1)'(1) || (!launch && !bus_valid_reg)); // see RULE7

  // Loads, stores and ordering barriers all go through the queue in program order, so
  // an uncached access can neither pass nor be passed by a barrier or another access.
  assign req_ready = (state_reg == MOSU_S_IDLE)
                     && ((!is_store && !is_order && req.op != MOSU_OP_LOAD) || !sq_full
                         || can_gather); // see RULE1 see RULE2 see RULE6
  assign push = req_valid && req_ready
                && (is_store || is_order || req.op == MOSU_OP_LOAD) && !can_gather;

  // A barrier at the head with broadcast off retires locally; it still waits its turn
  assign head_is_local_barrier = !sq_empty && sq_reg[0].barrier && !address_broadcast_enable;
  assign launch = !sq_empty && !bus_valid_reg && !head_is_local_barrier;          // see RULE5
  assign pop    = (bus_valid_reg && bus_ack && state_reg != MOSU_S_FULL_BCAST)
                  || head_is_local_barrier;

  always_comb begin
    merged_data = tail_entry.data;
    merged_be   = tail_entry.be;
    for (int i = 0; i < MOSU_BE_W; i++) begin
      if (req.be[i]) begin
        merged_data[i*8 +: 8] = req.data[i*8 +: 8];
        merged_be[i]          = 1'b1;
      end
    end
  end

  // Store queue: a shift-out FIFO; the head is entry zero
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sq_reg    <= '0;
      count_reg <= '0;
    end else begin
      if (pop) begin
        for (int i = 0; i < MOSU_SQ_DEPTH - 1; i++) begin
          sq_reg[i] <= sq_reg[i+1];
        end
        sq_reg[MOSU_SQ_DEPTH-1] <= '0;
      end
      if (push) begin
        sq_reg[count_reg - (MOSU_SQ_IDX_W+1)'(pop)] <= '{valid:    1'b1,
                                                        barrier:  is_order,
                                                        uncached: req.uncached,
                                                        addr:     req.addr,
                                                        data:     req.data,
                                                        be:       req.be};
      end else if (req_valid && req_ready && can_gather) begin
        // A pop in the same cycle moves the tail down by one slot
        sq_reg[count_reg - 1'b1 - (MOSU_SQ_IDX_W+1)'(pop)].data <= merged_data;
        sq_reg[count_reg - 1'b1 - (MOSU_SQ_IDX_W+1)'(pop)].be   <= merged_be;
      end
      count_reg <= count_reg + (MOSU_SQ_IDX_W+1)'(push) - (MOSU_SQ_IDX_W+1)'(pop);
    end
  end

  // Bus request holding register; barriers are tagged to skip the L2
  always_ff @(posedge clock) begin
    if (!rstn) begin
      bus_valid_reg <= 1'b0;
      bus_req_reg   <= '0;
      l2_bypass_reg <= 1'b0;
    end else if (bus_valid_reg) begin
      if (bus_ack) begin
        bus_valid_reg <= 1'b0;
        l2_bypass_reg <= 1'b0;
      end
    end else if (state_reg == MOSU_S_FULL_BCAST) begin
      // Issued once, after the drain; the queue is empty so nothing is popped on its ack
      bus_valid_reg <= 1'b1;
      bus_req_reg   <= '{kind: MOSU_BUS_FULL_BCAST, addr: '0, data: '0, be: '0};
      l2_bypass_reg <= 1'b1;
    end else if (launch) begin
      bus_valid_reg    <= 1'b1;
      bus_req_reg.addr <= sq_reg[0].addr;
      bus_req_reg.data <= sq_reg[0].data;
      bus_req_reg.be   <= sq_reg[0].be;
      if (sq_reg[0].barrier) begin
        bus_req_reg.kind <= MOSU_BUS_ORDER_BCAST;                             // see RULE3
        l2_bypass_reg    <= 1'b1;                                             // see RULE4
      end else begin
        bus_req_reg.kind <= (sq_reg[0].be == '0) ? MOSU_BUS_READ : MOSU_BUS_WRITE;
        l2_bypass_reg    <= sq_reg[0].uncached;
      end
    end
  end

  // Serialization sequencer; barrier latency depends on queue contents and bus acks
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg        <= MOSU_S_IDLE;
      iq_flush_reg     <= 1'b0;
      refetch_reg      <= 1'b0;
      exec_hold_reg    <= 1'b0;
      barrier_done_reg <= 1'b0;
    end else begin
      iq_flush_reg     <= 1'b0;
      refetch_reg      <= 1'b0;
      barrier_done_reg <= 1'b0;
      // Ordering barriers retire in any state, also while a full barrier drains
      if (head_is_local_barrier
          || (bus_valid_reg && bus_ack && bus_req_reg.kind == MOSU_BUS_ORDER_BCAST)) begin
        barrier_done_reg <= 1'b1;                                             // see RULE13
      end
      case (state_reg)
        MOSU_S_IDLE: begin
          if (req_valid && req_ready && req.op == MOSU_OP_INSN_SYNC) begin
            iq_flush_reg  <= 1'b1;                                            // see RULE9
            exec_hold_reg <= 1'b1;
            state_reg     <= MOSU_S_ISYNC_WAIT;
          end else if (req_valid && req_ready && req.op == MOSU_OP_FULL_BARRIER) begin
            exec_hold_reg <= 1'b1;
            state_reg     <= MOSU_S_FULL_DRAIN;
          end
        end
        // The store queue keeps draining here; only older instructions are waited for
        MOSU_S_ISYNC_WAIT: begin
          if (older_done) begin                                               // see RULE11
            refetch_reg <= 1'b1;                                              // see RULE9
            state_reg   <= MOSU_S_ISYNC_HOLD;
          end
        end
        MOSU_S_ISYNC_HOLD: begin
          if (older_no_except) begin                                          // see RULE10
            exec_hold_reg <= 1'b0;                                            // see RULE12
            state_reg     <= MOSU_S_IDLE;
          end
        end
        MOSU_S_FULL_DRAIN: begin
          if (sq_empty && !bus_valid_reg && older_no_except) begin
            if (address_broadcast_enable) begin
              state_reg <= MOSU_S_FULL_BCAST;
            end else begin
              exec_hold_reg    <= 1'b0;
              barrier_done_reg <= 1'b1;
              state_reg        <= MOSU_S_IDLE;
            end
          end
        end
        MOSU_S_FULL_BCAST: begin
          if (bus_valid_reg && bus_ack) begin                                 // see RULE14
            exec_hold_reg    <= 1'b0;
            barrier_done_reg <= 1'b1;
            state_reg        <= MOSU_S_IDLE;
          end
        end
        default: begin
          state_reg <= MOSU_S_IDLE;
        end
      endcase
    end
  end

  assign iq_flush     = iq_flush_reg;
  assign refetch      = refetch_reg;
  assign exec_hold    = exec_hold_reg;
  assign bus_valid    = bus_valid_reg;
  assign bus_req      = bus_req_reg;
  assign barrier_done = barrier_done_reg;
  assign l2_bypass    = l2_bypass_reg;

endmodule

`default_nettype wire

// >>> verification/mosu_core_sva.sv
// Checker for mosu_core: bus handshake, barrier and sync control timing.
// Assumes it sees only the ports of mosu_core; bound in below.
`timescale 1ns/1ps
`default_nettype none
module mosu_core_sva
  import mosu_pkg::*;
(
  input wire logic          clock,
  input wire logic          rstn,
  input wire logic          address_broadcast_enable,
  input wire logic          gather_enable,
  input wire logic          req_valid,
  input wire mosu_req_t     req,
  input wire logic          req_ready,
  input wire logic          older_done,
  input wire logic          older_no_except,
  input wire logic          iq_flush,
  input wire logic          refetch,
  input wire logic          exec_hold,
  input wire logic          bus_valid,
  input wire mosu_bus_req_t bus_req,
  input wire logic          bus_ack,
  input wire logic          barrier_done,
  input wire logic          l2_bypass
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic bcast;
  logic bcast_ack_reg;
  assign bcast = bus_req.kind inside {MOSU_BUS_ORDER_BCAST, MOSU_BUS_FULL_BCAST};
  always_ff @(posedge clock) begin
    bcast_ack_reg <= rstn && bus_valid && bus_ack && bcast;
  end
  bus_hold_a: assert property (bus_valid && !bus_ack |=> bus_valid && $stable(bus_req))
    else $error("bus request changed before ack");
  no_bcast_a: assert property (!address_broadcast_enable && bus_valid |-> !bcast)
    else $error("barrier broadcast with broadcast disabled");
  bcast_bypass_a: assert property (bus_valid && bcast |-> l2_bypass)
    else $error("barrier not bypassing L2");
  flush_hold_a: assert property (iq_flush |-> exec_hold && !$past(iq_flush))
    else $error("flush without hold or too long");
  refetch_wait_a: assert property (refetch |-> $past(older_done))
    else $error("refetch before older done");
  hold_release_a: assert property ($fell(exec_hold) |-> $past(older_no_except))
    else $error("hold dropped while older may except");
  hold_refuse_a: assert property (exec_hold |-> !req_ready)
    else $error("dispatch taken while held");
  done_bcast_a: assert property (address_broadcast_enable && barrier_done |-> bcast_ack_reg)
    else $error("barrier done without broadcast");
  cover property (bus_valid && bus_ack && bcast);
  cover property ($rose(refetch));
  cover property (barrier_done && !address_broadcast_enable);
endmodule
bind mosu_core mosu_core_sva u_sva (.clock(clock), .rstn(rstn),
  .address_broadcast_enable(address_broadcast_enable), .gather_enable(gather_enable),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .older_done(older_done),
  .older_no_except(older_no_except), .iq_flush(iq_flush), .refetch(refetch),
  .exec_hold(exec_hold), .bus_valid(bus_valid), .bus_req(bus_req), .bus_ack(bus_ack),
  .barrier_done(barrier_done), .l2_bypass(l2_bypass));
`default_nettype wire

// >>> verification/mosu_bus_model.sv
// Bus interface unit model: acknowledges each request after a set wait.
// Assumes the bench sets the wait; requests are taken whole, one at a time.
`timescale 1ns/1ps
`default_nettype none
module mosu_bus_model (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       bus_valid,
  input  wire logic [2:0] delay,
  output logic            bus_ack
);
  logic [2:0] wait_reg;
  always_ff @(posedge clock) begin
    if (!rstn || !bus_valid || bus_ack) begin
      wait_reg <= 3'h0;
    end else begin
      wait_reg <= wait_reg + 3'h1;
    end
  end
  // Never merges: each request is acked on its own
  assign bus_ack = bus_valid && (wait_reg >= delay);
endmodule
`default_nettype wire

// >>> verification/mosu_core_tb_top.sv
// Testbench for mosu_core: dispatch driver, bus monitor and event counters.
// Assumes mosu_bus_model answers the bus and the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module mosu_core_tb_top;
  import mosu_pkg::*;
  logic          clock, rstn, abe, gath, req_valid, older_done, no_exc;
  logic          req_ready, iq_flush, refetch, exec_hold, bus_valid, bus_ack;
  logic          barrier_done, l2_bypass;
  logic [2:0]    delay;
  mosu_req_t     req;
  mosu_bus_req_t bus_req;
  mosu_bus_req_t exp_q[$];
  int            err_count, comparisons, cycles, seed, n_done, n_ref, n_fl;
  mosu_core dut (.clock(clock), .rstn(rstn), .address_broadcast_enable(abe),
    .gather_enable(gath), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .older_done(older_done), .older_no_except(no_exc), .iq_flush(iq_flush),
    .refetch(refetch), .exec_hold(exec_hold), .bus_valid(bus_valid), .bus_req(bus_req),
    .bus_ack(bus_ack), .barrier_done(barrier_done), .l2_bypass(l2_bypass));
  mosu_bus_model bfm (.clock(clock), .rstn(rstn), .bus_valid(bus_valid), .delay(delay),
    .bus_ack(bus_ack));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic bad(input string m);
    $display("BAD %0t %s", $time, m);
    err_count++;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check_cnt(input int got, input int exp, input string m);
    comparisons++;
    if (got != exp) bad(m);
  endtask
  task automatic check_bus(input mosu_bus_req_t got);
    mosu_bus_req_t e;
    comparisons++;
    if (exp_q.size() == 0) begin
      bad("unexpected bus request");
      return;
    end
    e = exp_q.pop_front();
    if (got.kind !== e.kind || (e.kind == MOSU_BUS_WRITE && got !== e) ||
        (e.kind == MOSU_BUS_READ && got.addr !== e.addr)) bad("bus request differs");
  endtask
  // Called at a rising edge plus 1 ns; leaves req_valid high for back-to-back use
  task automatic send(input mosu_op_t op, input logic uc, input logic [31:0] a,
                      input logic [31:0] d, input logic [3:0] be);
    int n;
    mosu_bus_req_t e;
    req_valid = 1'b1;
    req = '{op, uc, a, d, be};
    e = '{MOSU_BUS_WRITE, a, d, be};
    if (op == MOSU_OP_LOAD) e.kind = MOSU_BUS_READ;
    if (op == MOSU_OP_ORDER_BARRIER) e.kind = MOSU_BUS_ORDER_BCAST;
    if (op == MOSU_OP_FULL_BARRIER) e.kind = MOSU_BUS_FULL_BCAST;
    if (op <= MOSU_OP_STORE || (abe && op != MOSU_OP_INSN_SYNC)) exp_q.push_back(e);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    if (n >= 200) bad("dispatch stalled");
    @(posedge clock);
    #1;
  endtask
  task automatic drain(input int t);
    int n;
    req_valid = 1'b0;
    n = 0;
    while ((exp_q.size() > 0 || bus_valid !== 1'b0) && n < 300) begin
      @(negedge clock);
      n++;
    end
    repeat (4) @(posedge clock);
    #1;
    check_cnt(exp_q.size(), 0, "bus requests missing");
    $display("test %0d done", t);
  endtask
  always @(negedge clock) begin
    if (rstn === 1'b1) begin
      if (bus_valid === 1'b1 && bus_ack === 1'b1) check_bus(bus_req);
      n_done += (barrier_done === 1'b1);
      n_ref += (refetch === 1'b1);
      n_fl += (iq_flush === 1'b1);
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad("timeout");
      report_and_stop();
    end
  end
  initial begin
    seed = 64700;
    {rstn, abe, gath, req_valid, older_done, no_exc} = 6'h0;
    req = '0;
    delay = 3'h0;
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    n_done = 0;
    n_ref = 0;
    n_fl = 0;
    repeat (2) @(posedge clock);
    #1 rstn = 1'b1;
    @(posedge clock);
    #1 abe = 1'b1;
    // Uncached loads and stores must reach the bus in program order
    for (int i = 0; i < 6; i++) begin
      delay = 3'($random(seed));
      send(i % 3 == 0 ? MOSU_OP_LOAD : MOSU_OP_STORE, 1'b1, $random(seed), $random(seed),
           i % 3 == 0 ? 4'h0 : 4'hf);
    end
    drain(1);
    // Gathering on: stores to one word either side of a barrier stay apart
    {older_done, no_exc, gath} = 3'h7;
    for (int k = 0; k < 2; k++) begin
      abe = (k == 0);
      delay = 3'h6;
      n_done = 0;
      send(MOSU_OP_STORE, 1'b0, 32'h0000_1000, 32'h1111_1111, 4'h3);
      send(MOSU_OP_ORDER_BARRIER, 1'b0, '0, '0, '0);
      send(MOSU_OP_STORE, 1'b0, 32'h0000_1000, 32'h2222_2222, 4'hc);
      send(MOSU_OP_FULL_BARRIER, 1'b0, '0, '0, '0);
      drain(2 + k);
      check_cnt(n_done, 2, "barrier completions");
    end
    // Instruction sync with a store still queued on a slow bus
    older_done = 1'b0;
    no_exc = 1'b0;
    n_ref = 0;
    n_fl = 0;
    delay = 3'h7;
    send(MOSU_OP_STORE, 1'b1, 32'h0000_2000, 32'h3333_3333, 4'hf);
    send(MOSU_OP_INSN_SYNC, 1'b0, '0, '0, '0);
    req_valid = 1'b0;
    repeat (5) @(posedge clock);
    #1 check_cnt(n_ref + n_fl, 1, "refetch before older done");
    older_done = 1'b1;
    repeat (3) @(posedge clock);
    #1 check_cnt(n_ref, 1, "refetch count");
    no_exc = 1'b1;
    send(MOSU_OP_STORE, 1'b1, 32'h0000_2004, 32'h4444_4444, 4'hf);
    drain(4);
    check_cnt(n_fl, 1, "flush count");
    report_and_stop();
  end
endmodule
`default_nettype wire
